// *** rtl/ampc_defs.svh ***
// Register field positions, reset values and timing counts of the memory port controller
// Overview of operation
// - Drive address and selects, then assert read strobe
// - Capture data bus, then release read strobe
// - Drive address and selects, then assert write strobe
// - Drive write data, keep setup before strobe release
// - Hold address and data after write strobe release
// - Predivider factor is field value plus one
// - Multiplier factor is twelve-bit field plus one
// - Output divider divides by two to field power
// - Single-bit clock controls at bits fifteen to nineteen
// - Core rate is input times multiplier over dividers
// - Five-bit wait counts for areas zero and one
// - Three-bit counts areas two, three; five-bit default
// - Bus state status, lock hold, request hold bits
// - Select pin asserts only on matching address, space
// - Bits zero to one choose area access type
// - Polarity bit and program, X, Y space enables
// - Low address byte swap bit and packing enable
// - Compare counted upper address bits against match value
// - Mode bits, external bus disable, memory switch bit
// - Acknowledge sync, bus release, select priority disable
`ifndef AMPC_DEFS_SVH
`define AMPC_DEFS_SVH

`define AMPC_REG_W        24
`define AMPC_ADDR_W       18
`define AMPC_DATA_W       24
`define AMPC_REG_SEL_W    3

// Register selects on the core register port
`define AMPC_SEL_PLL      3'h0
`define AMPC_SEL_BUS      3'h1
`define AMPC_SEL_AREA0    3'h2
`define AMPC_SEL_AREA1    3'h3
`define AMPC_SEL_AREA2    3'h4
`define AMPC_SEL_AREA3    3'h5
`define AMPC_SEL_MODE     3'h6
`define AMPC_SEL_STATUS   3'h7

// Clock control fields
`define AMPC_PLL_MF_LSB   0
`define AMPC_PLL_MF_W     12
`define AMPC_PLL_DF_LSB   12
`define AMPC_PLL_DF_W     3
`define AMPC_PLL_LOWXTAL  15
`define AMPC_PLL_XTALDIS  16
`define AMPC_PLL_STOPRUN  17
`define AMPC_PLL_ENABLE   18
`define AMPC_PLL_CLKODIS  19
`define AMPC_PLL_PD_LSB   20
`define AMPC_PLL_PD_W     4

// Bus wait control fields
`define AMPC_BUS_WS0_LSB  0
`define AMPC_BUS_WS1_LSB  5
`define AMPC_BUS_WS2_LSB  10
`define AMPC_BUS_WS3_LSB  13
`define AMPC_BUS_WSD_LSB  16
`define AMPC_BUS_STATE    21
`define AMPC_BUS_LOCKH    22
`define AMPC_BUS_REQH     23
`define AMPC_WS_WIDE_W    5
`define AMPC_WS_NARROW_W  3

// Area decode fields
`define AMPC_AREA_TYPE_LSB 0
`define AMPC_AREA_POL     2
`define AMPC_AREA_PEN     3
`define AMPC_AREA_XEN     4
`define AMPC_AREA_YEN     5
`define AMPC_AREA_SWAP    6
`define AMPC_AREA_PACK    7
`define AMPC_AREA_NCMP_LSB 8
`define AMPC_AREA_MATCH_LSB 12
`define AMPC_AREA_MATCH_W 12

// Operating mode fields
`define AMPC_MODE_MD_LSB  0
`define AMPC_MODE_EXTDIS  4
`define AMPC_MODE_MSW     7
`define AMPC_MODE_TASYNC  11
`define AMPC_MODE_BRT     12
`define AMPC_MODE_APD     14

// Reset values
`define AMPC_PLL_RST      24'h000000
`define AMPC_BUS_RST      24'h1fffff
`define AMPC_AREA_RST     24'h000000
`define AMPC_MODE_RST     24'h000000
`define AMPC_STATUS_RST   24'h000000

// Fixed strobe timing in core cycles
`define AMPC_ADDR_SETUP_CYC 4'h1
`define AMPC_ADDR_HOLD_CYC  4'h1

`endif

// *** rtl/ampc_pkg.sv ***
// Types shared by the memory port controller
package ampc_pkg;
  typedef enum logic [2:0] {
    AMPC_IDLE  = 3'b000,
    AMPC_SETUP = 3'b001,
    AMPC_STRB  = 3'b011,
    AMPC_HOLD  = 3'b010
  } ampc_state_t;

  typedef enum logic [1:0] {
    AMPC_SPACE_P = 2'h0,
    AMPC_SPACE_X = 2'h1,
    AMPC_SPACE_Y = 2'h2
  } ampc_space_t;

  typedef enum logic [1:0] {
    AMPC_TYPE_SYNC  = 2'h0,
    AMPC_TYPE_ASYNC = 2'h1,
    AMPC_TYPE_DRAM  = 2'h2
  } ampc_access_t;
endpackage : ampc_pkg

// *** rtl/ampc_port_ctrl.sv ***
// External asynchronous memory port controller with its control registers
`timescale 1ns/1ps
`default_nettype none
`include "ampc_defs.svh"

module ampc_port_ctrl #(
  parameter int ADDR_W = `AMPC_ADDR_W,
  parameter int DATA_W = `AMPC_DATA_W
) (
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // Core register port
  input  wire logic                       regWrite,
  input  wire logic [`AMPC_REG_SEL_W-1:0] regSel,
  input  wire logic [`AMPC_REG_W-1:0]     regWdata,
  output logic      [`AMPC_REG_W-1:0]     regRdata,
  // Core access request
  input  wire logic                       accReq,
  input  wire logic                       accWrite,
  input  wire ampc_pkg::ampc_space_t      accSpace,
  input  wire logic [`AMPC_REG_W-1:0]     accAddr,
  input  wire logic [DATA_W-1:0]          accWdata,
  output logic                            accReady,
  output logic                            accDone,
  output logic      [DATA_W-1:0]          accRdata,
  // Memory pins
  output logic      [ADDR_W-1:0]          memAddr,
  output logic      [3:0]                 attribute_select,
  output logic                            memReadN,
  output logic                            memWriteN,
  input  wire logic [DATA_W-1:0]          memDataIn,
  output logic      [DATA_W-1:0]          memDataOut,
  output logic                            memDataOe,
  // Clock generator controls
  output logic      [4:0]                 input_predivider,
  output logic      [12:0]                pll_multiplier,
  output logic      [7:0]                 output_divider,
  output logic                            lowFreqXtal,
  output logic                            xtalDriveDis,
  output logic                            pllStopRun,
  output logic                            pllEnable,
  output logic                            coreClkOutDis,
  // Mode and bus control outputs
  output logic      [3:0]                 mode_select_bits,
  output logic                            memSwitch,
  output logic                            transfer_acknowledge_nSync,
  output logic                            bus_busy_nFast,
  output logic                            busLockHold,
  output logic                            busRequestHold
);
  import ampc_pkg::*;

  logic [`AMPC_REG_W-1:0] pllCtrl_q, busWait_q, opMode_q, coreStatus_q;
  logic [`AMPC_REG_W-1:0] areaDecode_q [4];
  ampc_state_t            state_q, state_d;
  logic [4:0]             waitCnt_q, waitCnt_d;
  logic                   isWrite_q;
  logic [3:0]             selRaw_q;
  logic [ADDR_W-1:0]      addr_q;
  logic [DATA_W-1:0]      wdata_q, rdata_q;
  logic                   done_q;

  // Compare the top ncmp bits (at most twelve) of a 24-bit address with the match field
  function automatic logic areaHit(input logic [`AMPC_REG_W-1:0] cfg,
                                   input logic [`AMPC_REG_W-1:0] addr,
                                   input ampc_space_t space);
    logic [3:0]  ncmp;
    logic [11:0] mask;
    logic        spaceOk;
    ncmp = cfg[`AMPC_AREA_NCMP_LSB +: 4];
    mask = (ncmp >= 4'hc) ? 12'hfff : ~(12'hfff >> ncmp);
    unique case (space)
      AMPC_SPACE_P: spaceOk = cfg[`AMPC_AREA_PEN];
      AMPC_SPACE_X: spaceOk = cfg[`AMPC_AREA_XEN];
      AMPC_SPACE_Y: spaceOk = cfg[`AMPC_AREA_YEN];
      default:      spaceOk = 1'b0;
    endcase
    areaHit = spaceOk &&
      (((addr[23:12] ^ cfg[`AMPC_AREA_MATCH_LSB +: `AMPC_AREA_MATCH_W]) & mask) == 12'h000);
  endfunction

  // Decode
  wire [3:0] hitRaw;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_hit
    assign hitRaw[gi] = areaHit(areaDecode_q[gi], accAddr, accSpace);
  end
  wire       prioDis = opMode_q[`AMPC_MODE_APD];
  wire [3:0] hitPrio = hitRaw[0] ? 4'h1 : hitRaw[1] ? 4'h2 : hitRaw[2] ? 4'h4 :
                       hitRaw[3] ? 4'h8 : 4'h0;
  wire [3:0] hitSel  = prioDis ? hitRaw : hitPrio;

  wire [4:0] ws0 = busWait_q[`AMPC_BUS_WS0_LSB +: 5];
  wire [4:0] ws1 = busWait_q[`AMPC_BUS_WS1_LSB +: 5];
  wire [4:0] ws2 = {2'b00, busWait_q[`AMPC_BUS_WS2_LSB +: 3]};
  wire [4:0] ws3 = {2'b00, busWait_q[`AMPC_BUS_WS3_LSB +: 3]};
  wire [4:0] wsD = busWait_q[`AMPC_BUS_WSD_LSB +: 5];
  wire [4:0] wsSel = hitSel[0] ? ws0 : hitSel[1] ? ws1 : hitSel[2] ? ws2 :
                     hitSel[3] ? ws3 : wsD;

  // Byte swap moves the low eight address bits to the top of the pins
  wire       swapSel = |(hitSel & {areaDecode_q[3][`AMPC_AREA_SWAP],
                          areaDecode_q[2][`AMPC_AREA_SWAP],
                          areaDecode_q[1][`AMPC_AREA_SWAP],
                          areaDecode_q[0][`AMPC_AREA_SWAP]});
  wire [ADDR_W-1:0] addrPlain = accAddr[ADDR_W-1:0];
  wire [ADDR_W-1:0] addrSwap  = {accAddr[7:0], accAddr[ADDR_W-1:8]};

  wire extDis  = opMode_q[`AMPC_MODE_EXTDIS];
  wire start   = (state_q == AMPC_IDLE) && accReq && !extDis;
  assign accReady = (state_q == AMPC_IDLE) && !extDis;

  // Access sequencer
  always_comb begin
    state_d   = state_q;
    waitCnt_d = waitCnt_q;
    unique case (state_q)
      AMPC_IDLE: if (start) begin
        state_d = AMPC_SETUP;
      end
      AMPC_SETUP: begin
        state_d = AMPC_STRB;
      end
      AMPC_STRB: if (waitCnt_q == 5'h00) begin
        state_d = AMPC_HOLD;
      end else begin
        waitCnt_d = waitCnt_q - 5'h01;
      end
      AMPC_HOLD: begin
        state_d = AMPC_IDLE;
      end
      default: state_d = AMPC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= AMPC_IDLE;
      waitCnt_q <= 5'h00;
      isWrite_q <= 1'b0;
      selRaw_q  <= 4'h0;
      addr_q    <= '0;
      wdata_q   <= '0;
    end else begin
      state_q <= state_d;
      waitCnt_q <= start ? wsSel : waitCnt_d;
      if (start) begin
        isWrite_q <= accWrite;
        selRaw_q  <= hitSel;
        addr_q    <= swapSel ? addrSwap : addrPlain;
        wdata_q   <= accWdata;
      end
    end
  end

  // Read capture happens on the last strobe cycle, before release
  wire lastStrb = (state_q == AMPC_STRB) && (waitCnt_q == 5'h00);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= lastStrb;
      if (lastStrb && !isWrite_q) begin
        rdata_q <= memDataIn;
      end
    end
  end
  assign accDone  = done_q;
  assign accRdata = rdata_q;

  // Pins: address and selects stand for setup, strobe and hold
  wire busy = (state_q != AMPC_IDLE);
  wire [3:0] polMask = {areaDecode_q[3][`AMPC_AREA_POL], areaDecode_q[2][`AMPC_AREA_POL],
                        areaDecode_q[1][`AMPC_AREA_POL], areaDecode_q[0][`AMPC_AREA_POL]};
  // Polarity bit clear gives an active-low pin, set gives active-high
  assign attribute_select = (busy ? selRaw_q : 4'h0) ~^ polMask;
  assign memAddr    = addr_q;
  assign memReadN   = !((state_q == AMPC_STRB) && !isWrite_q);
  assign memWriteN  = !((state_q == AMPC_STRB) && isWrite_q);
  assign memDataOut = wdata_q;
  assign memDataOe  = isWrite_q && (state_q == AMPC_STRB || state_q == AMPC_HOLD);

  // Register port
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pllCtrl_q       <= `AMPC_PLL_RST;
      busWait_q       <= `AMPC_BUS_RST;
      opMode_q        <= `AMPC_MODE_RST;
      coreStatus_q    <= `AMPC_STATUS_RST;
      areaDecode_q[0] <= `AMPC_AREA_RST;
      areaDecode_q[1] <= `AMPC_AREA_RST;
      areaDecode_q[2] <= `AMPC_AREA_RST;
      areaDecode_q[3] <= `AMPC_AREA_RST;
    end else if (regWrite) begin
      unique case (regSel)
        `AMPC_SEL_PLL:    pllCtrl_q <= regWdata;
        `AMPC_SEL_BUS:    busWait_q <= regWdata;
        `AMPC_SEL_AREA0:  areaDecode_q[0] <= regWdata;
        `AMPC_SEL_AREA1:  areaDecode_q[1] <= regWdata;
        `AMPC_SEL_AREA2:  areaDecode_q[2] <= regWdata;
        `AMPC_SEL_AREA3:  areaDecode_q[3] <= regWdata;
        `AMPC_SEL_MODE:   opMode_q <= regWdata;
        `AMPC_SEL_STATUS: coreStatus_q <= regWdata;
      endcase
    end
  end

  // Bus state status reads live; stored bit 21 is not read back
  wire [`AMPC_REG_W-1:0] busRead = {busWait_q[23:22], busy, busWait_q[20:0]};
  assign regRdata = (regSel == `AMPC_SEL_PLL)   ? pllCtrl_q :
                    (regSel == `AMPC_SEL_BUS)   ? busRead :
                    (regSel == `AMPC_SEL_AREA0) ? areaDecode_q[0] :
                    (regSel == `AMPC_SEL_AREA1) ? areaDecode_q[1] :
                    (regSel == `AMPC_SEL_AREA2) ? areaDecode_q[2] :
                    (regSel == `AMPC_SEL_AREA3) ? areaDecode_q[3] :
                    (regSel == `AMPC_SEL_MODE)  ? opMode_q : coreStatus_q;

  // Clock generator factors; core rate = input * mult / (prediv * outdiv)
  assign input_predivider = {1'b0, pllCtrl_q[`AMPC_PLL_PD_LSB +: 4]} + 5'h01;
  assign pll_multiplier   = {1'b0, pllCtrl_q[`AMPC_PLL_MF_LSB +: 12]} + 13'h0001;
  assign output_divider   = 8'h01 << pllCtrl_q[`AMPC_PLL_DF_LSB +: 3];
  assign lowFreqXtal      = pllCtrl_q[`AMPC_PLL_LOWXTAL];
  assign xtalDriveDis     = pllCtrl_q[`AMPC_PLL_XTALDIS];
  assign pllStopRun       = pllCtrl_q[`AMPC_PLL_STOPRUN];
  assign pllEnable        = pllCtrl_q[`AMPC_PLL_ENABLE];
  assign coreClkOutDis    = pllCtrl_q[`AMPC_PLL_CLKODIS];

  assign mode_select_bits           = opMode_q[`AMPC_MODE_MD_LSB +: 4];
  assign memSwitch                  = opMode_q[`AMPC_MODE_MSW];
  assign transfer_acknowledge_nSync = opMode_q[`AMPC_MODE_TASYNC];
  assign bus_busy_nFast             = opMode_q[`AMPC_MODE_BRT];
  assign busLockHold                = busWait_q[`AMPC_BUS_LOCKH];
  assign busRequestHold             = busWait_q[`AMPC_BUS_REQH];

endmodule : ampc_port_ctrl
`default_nettype wire

// *** testbench/ampc_port_ctrl_asserts.sv ***
// Pin timing and register field checks for the memory port controller
`timescale 1ns/1ps
`default_nettype none
`include "ampc_defs.svh"
module ampc_port_ctrl_asserts #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 24
) (
  input wire logic                       ref_clk,
  input wire logic                       resetn,
  input wire logic                       regWrite,
  input wire logic [`AMPC_REG_SEL_W-1:0] regSel,
  input wire logic [`AMPC_REG_W-1:0]     regWdata,
  input wire logic                       accReq,
  input wire logic                       accWrite,
  input wire logic                       accReady,
  input wire logic                       accDone,
  input wire logic [ADDR_W-1:0]          memAddr,
  input wire logic [3:0]                 attribute_select,
  input wire logic                       memReadN,
  input wire logic                       memWriteN,
  input wire logic [DATA_W-1:0]          memDataOut,
  input wire logic                       memDataOe,
  input wire logic [4:0]                 input_predivider,
  input wire logic [12:0]                pll_multiplier,
  input wire logic [7:0]                 output_divider
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire take   = accReq && accReady;
  wire pllWr  = regWrite && regSel == `AMPC_SEL_PLL;
  wire extOff = regWrite && regSel == `AMPC_SEL_MODE && regWdata[`AMPC_MODE_EXTDIS];
  wire [3:0]  pdIn = regWdata[`AMPC_PLL_PD_LSB +: 4];
  wire [11:0] mfIn = regWdata[`AMPC_PLL_MF_LSB +: 12];
  wire [2:0]  dfIn = regWdata[`AMPC_PLL_DF_LSB +: 3];
  sequence s_rd_start; memReadN ##1 !memReadN; endsequence
  sequence s_wr_start; memWriteN ##1 !memWriteN; endsequence
  sequence s_wait_done; !accDone [*2] ##[1:33] accDone; endsequence
  property p_rd_order; take && !accWrite |=> s_rd_start; endproperty
  a_rd_order: assert property (p_rd_order) else $error("read strobe not after address");
  property p_wr_order; take && accWrite |=> s_wr_start; endproperty
  a_wr_order: assert property (p_wr_order) else $error("write strobe not after address");
  property p_strb_addr;
    !memReadN || !memWriteN |-> $stable(memAddr) && $stable(attribute_select);
  endproperty
  a_strb_addr: assert property (p_strb_addr) else $error("address moved under strobe");
  property p_rd_end; $rose(memReadN) |-> accDone; endproperty
  a_rd_end: assert property (p_rd_end) else $error("read released without completion");
  property p_wr_oe; !memWriteN |-> memDataOe; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write data not driven");
  property p_wr_hold;
    $rose(memWriteN) |-> $stable(memAddr) && $stable(attribute_select) && $stable(memDataOut);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("address or data not held");
  property p_done_time; take |=> s_wait_done; endproperty
  a_done_time: assert property (p_done_time) else $error("completion out of window");
  property p_pd; pllWr |=> input_predivider == {1'b0, $past(pdIn)} + 5'h1; endproperty
  a_pd: assert property (p_pd) else $error("predivider factor wrong");
  property p_mf; pllWr |=> pll_multiplier == {1'b0, $past(mfIn)} + 13'h1; endproperty
  a_mf: assert property (p_mf) else $error("multiplier factor wrong");
  property p_df; pllWr |=> output_divider == 8'h1 << $past(dfIn); endproperty
  a_df: assert property (p_df) else $error("output divider wrong");
  property p_ext_off; extOff |=> !accReady; endproperty
  a_ext_off: assert property (p_ext_off) else $error("ready while bus disabled");
endmodule // ampc_port_ctrl_asserts
`default_nettype wire

// *** testbench/ampc_mem_model.sv ***
// Asynchronous memory on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module ampc_mem_model #(
  parameter int ACC_NS = 30
) (
  input  wire logic        selN,
  input  wire logic        rdN,
  input  wire logic        wrN,
  input  wire logic [17:0] addr,
  input  wire logic [23:0] din,
  output logic      [23:0] dq
);
  logic [23:0] mem [256];
  initial dq = 24'h5a5a5a;
  // Bus is garbage until the access time has run out
  always @(rdN or selN) begin
    dq = ~dq;
    if (!rdN && !selN) begin
      #(ACC_NS);
      if (!rdN && !selN) dq = mem[addr[7:0]];
    end
  end
  always @(posedge wrN) if (!selN) mem[addr[7:0]] <= din;
endmodule // ampc_mem_model
`default_nettype wire

// *** testbench/test_ampc_port_ctrl.sv ***
// Self-checking bench for the memory port controller
`timescale 1ns/1ps
`default_nettype none
`include "ampc_defs.svh"
module test_ampc_port_ctrl;
  import ampc_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, accReq = 1'b0, accWrite = 1'b0;
  logic [2:0] regSel = 3'h0;
  logic [23:0] regWdata = 24'h0, accAddr = 24'h0, accWdata = 24'h0;
  ampc_space_t accSpace = AMPC_SPACE_P;
  logic [23:0] regRdata, accRdata, memDataIn, memDataOut;
  logic accReady, accDone, memReadN, memWriteN, memDataOe, lowFreqXtal, xtalDriveDis;
  logic pllStopRun, pllEnable, coreClkOutDis, memSwitch, transfer_acknowledge_nSync;
  logic bus_busy_nFast, busLockHold, busRequestHold;
  logic [17:0] memAddr;
  logic [3:0] attribute_select, mode_select_bits;
  logic [4:0] input_predivider;
  logic [12:0] pll_multiplier;
  logic [7:0] output_divider;
  int error_cnt = 0;
  int n_tests = 0;
  ampc_port_ctrl dut_u (.ref_clk, .resetn, .regWrite, .regSel, .regWdata, .regRdata, .accReq,
    .accWrite, .accSpace, .accAddr, .accWdata, .accReady, .accDone, .accRdata, .memAddr,
    .attribute_select, .memReadN, .memWriteN, .memDataIn, .memDataOut, .memDataOe,
    .input_predivider, .pll_multiplier, .output_divider, .lowFreqXtal, .xtalDriveDis,
    .pllStopRun, .pllEnable, .coreClkOutDis, .mode_select_bits, .memSwitch,
    .transfer_acknowledge_nSync, .bus_busy_nFast, .busLockHold, .busRequestHold);
  ampc_mem_model mem_u (.selN(attribute_select[1]), .rdN(memReadN), .wrN(memWriteN),
    .addr(memAddr), .din(memDataOut), .dq(memDataIn));
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [2:0] sel, input logic [23:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regSel <= sel;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] sel, input logic [23:0] exp);
    @(posedge ref_clk);
    regSel <= sel;
    #1 chk(regRdata, exp);
  endtask
  // One access; pins are sampled in the first strobe cycle
  task automatic acc(input logic wr, input ampc_space_t sp, input logic [23:0] a,
                     input logic [3:0] es, input int w);
    int cyc;
    logic [21:0] pins;
    @(posedge ref_clk);
    accReq <= 1'b1;
    accWrite <= wr;
    accSpace <= sp;
    accAddr <= a;
    accWdata <= 24'ha5a5a5;
    cyc = 0;
    do @(posedge ref_clk); while (accReady !== 1'b1 && ++cyc < 40);
    accReq <= 1'b0;
    @(posedge ref_clk);
    #1 pins = {attribute_select, memAddr};
    cyc = 1;
    do begin
      @(posedge ref_clk);
      cyc++;
    end while (accDone !== 1'b1 && cyc < 60);
    chk({2'b0, pins}, {2'b0, es, a[17:0]});
    chk(24'(cyc), 24'(3 + w));
    if (!wr && !es[1]) chk(accRdata, 24'ha5a5a5);
  endtask
  task automatic t_pll(input logic [23:0] v, input logic [23:0] pdMf, input logic [7:0] df,
                       input logic [4:0] bits);
    reg_wr(`AMPC_SEL_PLL, v);
    reg_rd(`AMPC_SEL_PLL, v);
    chk({input_predivider, pll_multiplier}, pdMf);
    chk(output_divider, df);
    chk({lowFreqXtal, xtalDriveDis, pllStopRun, pllEnable, coreClkOutDis}, bits);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    reg_rd(`AMPC_SEL_BUS, `AMPC_BUS_RST);
    chk({input_predivider, pll_multiplier}, 24'h002001);
    chk(output_divider, 24'h1);
    $display("reset test done");
    t_pll(24'h0e0013, 24'h002014, 8'h1, 5'b00111);
    t_pll(24'hf1ffff, 24'h021000, 8'h80, 5'b11000);
    $display("clock test done");
    reg_wr(`AMPC_SEL_BUS, 24'he57c40);
    reg_rd(`AMPC_SEL_BUS, 24'hc57c40);
    chk({busLockHold, busRequestHold}, 24'h3);
    $display("bus test done");
    reg_wr(`AMPC_SEL_AREA1, 24'hd00c09);
    reg_wr(`AMPC_SEL_AREA2, 24'h200421);
    reg_wr(`AMPC_SEL_AREA3, 24'h000015);
    reg_rd(`AMPC_SEL_AREA2, 24'h200421);
    acc(1'b1, AMPC_SPACE_P, 24'hd00012, 4'b0101, 2);
    acc(1'b0, AMPC_SPACE_P, 24'hd00012, 4'b0101, 2);
    acc(1'b0, AMPC_SPACE_Y, 24'h2abcde, 4'b0011, 7);
    acc(1'b1, AMPC_SPACE_X, 24'h123456, 4'b1111, 3);
    acc(1'b0, AMPC_SPACE_P, 24'h100000, 4'b0111, 5);
    $display("access test done");
    reg_wr(`AMPC_SEL_MODE, 24'h00589f);
    #1 chk({mode_select_bits, memSwitch, transfer_acknowledge_nSync, bus_busy_nFast,
            accReady}, 24'hfe);
    reg_wr(`AMPC_SEL_MODE, 24'h0);
    $display("mode test done");
    reg_wr(`AMPC_SEL_AREA1, 24'hd00c19);
    reg_wr(`AMPC_SEL_MODE, 24'h004000);
    acc(1'b0, AMPC_SPACE_X, 24'hd00012, 4'b1101, 2);
    reg_wr(`AMPC_SEL_MODE, 24'h0);
    $display("priority test done");
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end
endmodule // test_ampc_port_ctrl
bind ampc_port_ctrl ampc_port_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .ref_clk, .resetn, .regWrite, .regSel, .regWdata, .accReq, .accWrite, .accReady, .accDone,
  .memAddr, .attribute_select, .memReadN, .memWriteN, .memDataOut, .memDataOe,
  .input_predivider, .pll_multiplier, .output_divider);
`default_nettype wire
